/* logic/crwc_core_ctrl.sv */
// core restart, wait mode and cycle timing control
// Function
// - reset clears stack, loads reset vector PC
// - after reset core enters non-maskable mode
// - return ends restart, normal mode, serve pending
// - stop instruction behaves exactly like wait
// - wait halts execution, clocks keep running
// - timers run in wait; timer irq wakes
// - reset during wait gives full reset
// - wake from wait without added delay
// - wait wake only when global enable set
// - wait from main: wake and service interrupt
// - wait in nmi routine: resume, no service
// - wait in irq, irq wakes: resume routine
// - wait in irq, nmi wakes: nmi first
// - skip wait when enabled request pending
// - all sources disabled: only reset wakes
// - machine cycle is thirteen oscillator periods
// - oscillator divided by twelve for ticks
// - instruction takes five, four or two cycles
// - reset latched, released after 2048 clocks
// - global enable gates maskable, nmi exempt running
module crwc_core_ctrl
  import crwc_pkg::*;
#(
  parameter int RST_HOLD = RST_HOLD_CLKS
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         rst_pin_n_i,
  input  wire logic         wdg_rst_i,
  input  wire logic         global_irq_enable_i,
  input  wire logic         irq_req_i,
  input  wire logic         nmi_req_i,
  input  wire logic         wait_exec_i,
  input  wire logic         stop_exec_i,
  input  wire logic         return_from_interrupt_exec_i,
  input  wire logic         instr_start_i,
  input  wire crwc_iclass_t instr_class_i,
  input  wire logic [11:0]  vec_data_i,
  output logic              core_reset_o,
  output logic              stack_clear_o,
  output logic [11:0]       vec_addr_o,
  output logic              pc_load_o,
  output logic [11:0]       pc_o,
  output logic [1:0]        mode_o,
  output logic              halted_o,
  output logic              irq_take_o,
  output logic              nmi_take_o,
  output logic              periph_clk_en_o,
  output logic              mcyc_stb_o,
  output logic              tick_stb_o,
  output logic              instr_done_o
);
  initial begin
    if (RST_HOLD < 1 || RST_HOLD > 65535) begin
      $error("crwc_core_ctrl: reset hold out of range");
    end
  end

  crwc_mode_t  mode_r;
  crwc_mode_t  wait_mode_r;
  logic [15:0] hold_r;
  logic        rst_req;
  logic [1:0]  vec_step_r;
  logic [2:0]  cyc_left_r;
  logic [2:0]  cyc_nxt;
  logic        halt_req;
  logic        irq_ok;
  logic        nmi_ok;
  logic        wake;

  assign rst_req = !rst_pin_n_i || wdg_rst_i;
  // stop is redirected onto the wait path; no true stop exists
  assign halt_req = wait_exec_i || stop_exec_i;
  // in run mode nmi ignores global enable, in wait it does not
  assign irq_ok = global_irq_enable_i && irq_req_i && (mode_r == CRWC_MODE_NORMAL);
  assign nmi_ok = nmi_req_i && (mode_r != CRWC_MODE_NMI);
  // any pending source wakes, but only with global enable set
  assign wake = global_irq_enable_i && (irq_req_i || nmi_req_i);

  crwc_clk_div u_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .mcyc_stb_o (mcyc_stb_o),
    .tick_stb_o (tick_stb_o)
  );

  // reset latch: held while requested, then stretched
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      hold_r       <= 16'(RST_HOLD); // system reset is stretched too, else it never ends
    end else if (rst_req) begin
      core_reset_o <= 1'b1;
      hold_r       <= 16'(RST_HOLD);
    end else if (hold_r > 16'h0001) begin
      hold_r <= hold_r - 16'h0001;
    end else if (hold_r == 16'h0001) begin
      hold_r       <= 16'h0000;
      core_reset_o <= 1'b0;
    end
  end

  // reset vector fetch: low then high address after release, PC taken from the high-address read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_step_r    <= 2'h0;
      vec_addr_o    <= RST_VEC_LO_ADDR;
      pc_o          <= 12'h000;
      pc_load_o     <= 1'b0;
      stack_clear_o <= 1'b1;
    end else if (core_reset_o) begin
      vec_step_r    <= 2'h1;
      vec_addr_o    <= RST_VEC_LO_ADDR;
      pc_load_o     <= 1'b0;
      stack_clear_o <= 1'b1;
    end else begin
      stack_clear_o <= 1'b0;
      pc_load_o     <= 1'b0;
      unique case (vec_step_r)
        2'h1: begin
          vec_addr_o <= RST_VEC_HI_ADDR;
          vec_step_r <= 2'h2;
        end
        2'h2: begin
          pc_o       <= vec_data_i;
          pc_load_o  <= 1'b1;
          vec_step_r <= 2'h0;
        end
        default: begin
          vec_step_r <= 2'h0;
        end
      endcase
    end
  end

  // mode tracking and interrupt acceptance
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r      <= CRWC_MODE_NMI;
      wait_mode_r <= CRWC_MODE_NORMAL;
      halted_o    <= 1'b0;
      irq_take_o  <= 1'b0;
      nmi_take_o  <= 1'b0;
    end else if (core_reset_o) begin
      mode_r     <= CRWC_MODE_NMI;
      wait_mode_r <= CRWC_MODE_NORMAL; // stale wait context must not steer the restart return
      halted_o   <= 1'b0;
      irq_take_o <= 1'b0;
      nmi_take_o <= 1'b0;
    end else if (halted_o) begin
      irq_take_o <= 1'b0;
      nmi_take_o <= 1'b0;
      if (wake) begin
        halted_o <= 1'b0;
        unique case (wait_mode_r)
          CRWC_MODE_NORMAL: begin
            nmi_take_o <= nmi_req_i;
            irq_take_o <= !nmi_req_i;
            mode_r     <= nmi_req_i ? CRWC_MODE_NMI : CRWC_MODE_IRQ;
          end
          CRWC_MODE_IRQ: begin
            nmi_take_o <= nmi_req_i;
            mode_r     <= nmi_req_i ? CRWC_MODE_NMI : CRWC_MODE_IRQ;
          end
          CRWC_MODE_NMI: begin
            mode_r <= CRWC_MODE_NMI;
          end
          default: begin
            mode_r <= CRWC_MODE_NMI;
          end
        endcase
      end
    end else begin
      nmi_take_o <= nmi_ok;
      irq_take_o <= irq_ok && !nmi_ok;
      if (nmi_ok) begin
        mode_r <= CRWC_MODE_NMI;
      end else if (irq_ok) begin
        mode_r <= CRWC_MODE_IRQ;
      end else if (return_from_interrupt_exec_i) begin
        mode_r <= (mode_r == CRWC_MODE_NMI && wait_mode_r == CRWC_MODE_IRQ) ?
                  CRWC_MODE_IRQ : CRWC_MODE_NORMAL;
        // a return uses up the saved wait context once
        wait_mode_r <= CRWC_MODE_NORMAL;
      end else if (halt_req && !(nmi_ok || irq_ok || wake)) begin
        halted_o    <= 1'b1;
        wait_mode_r <= mode_r;
      end
    end
  end

  // peripherals stay clocked through wait so timers can wake the core
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      periph_clk_en_o <= 1'b0;
    end else begin
      periph_clk_en_o <= !core_reset_o;
    end
  end

  assign mode_o = mode_r;

  // instruction duration in machine cycles
  always_comb begin
    unique case (instr_class_i)
      CRWC_IC_BIT_BRANCH:  cyc_nxt = CYC_BIT_BRANCH;
      CRWC_IC_COND_BRANCH,
      CRWC_IC_PROG_CTRL:   cyc_nxt = CYC_TWO;
      default:             cyc_nxt = CYC_FOUR;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_left_r   <= 3'h0;
      instr_done_o <= 1'b0;
    end else begin
      instr_done_o <= 1'b0;
      if (core_reset_o || halted_o) begin
        cyc_left_r <= 3'h0;
      end else if (instr_start_i && cyc_left_r == 3'h0) begin
        cyc_left_r <= cyc_nxt;
      end else if (mcyc_stb_o && cyc_left_r != 3'h0) begin
        cyc_left_r   <= cyc_left_r - 3'h1;
        instr_done_o <= (cyc_left_r == 3'h1);
      end
    end
  end

  property p_reset_nmi;
    @(posedge core_clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> mode_o == 2'(CRWC_MODE_NMI);
  endproperty
  a_reset_nmi: assert property (p_reset_nmi) else $error("not nmi mode after reset");

  property p_reset_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      $fell(rst_req) |-> core_reset_o;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early");

  // high vector byte addressed, then the program counter loaded
  sequence s_vec_fetch;
    ##1 vec_addr_o == RST_VEC_HI_ADDR ##1 pc_load_o;
  endsequence

  property p_vec_load;
    @(posedge core_clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> s_vec_fetch;
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("reset vector not loaded");

  property p_no_wake_gen0;
    @(posedge core_clk_i) disable iff (rst_i)
      halted_o && !global_irq_enable_i && !core_reset_o |=> halted_o;
  endproperty
  a_no_wake_gen0: assert property (p_no_wake_gen0) else $error("woke with enable clear");

  property p_wake_fast;
    @(posedge core_clk_i) disable iff (rst_i)
      halted_o && wake |=> !halted_o;
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("wake delayed");

  property p_nmi_wait_stay;
    @(posedge core_clk_i) disable iff (rst_i)
      halted_o && wake && wait_mode_r == CRWC_MODE_NMI && !core_reset_o
        |=> !irq_take_o && !nmi_take_o && mode_o == 2'(CRWC_MODE_NMI);
  endproperty
  a_nmi_wait_stay: assert property (p_nmi_wait_stay) else $error("serviced in nmi wait");

  property p_skip_wait;
    @(posedge core_clk_i) disable iff (rst_i)
      !halted_o && !core_reset_o && halt_req && wake |=> !halted_o;
  endproperty
  a_skip_wait: assert property (p_skip_wait) else $error("wait entered with pending");

  property p_stop_as_wait;
    @(posedge core_clk_i) disable iff (rst_i)
      !halted_o && !core_reset_o && stop_exec_i && !wake && !nmi_ok && !return_from_interrupt_exec_i |=> halted_o;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) else $error("stop not treated as wait");

  property p_periph_run;
    @(posedge core_clk_i) disable iff (rst_i)
      halted_o && !core_reset_o |-> periph_clk_en_o;
  endproperty
  a_periph_run: assert property (p_periph_run) else $error("peripherals stopped in wait");
endmodule : crwc_core_ctrl

/* common/crwc_pkg.sv */
// package: constants and types for the core restart / wait control block
package crwc_pkg;
  // reset vector locations in program memory
  localparam logic [11:0] RST_VEC_LO_ADDR = 12'h0ffe;
  localparam logic [11:0] RST_VEC_HI_ADDR = 12'h0fff;
  // oscillator periods per machine cycle and per timer tick
  localparam int MCYC_PERIODS   = 13;
  localparam int TICK_PERIODS   = 12;
  // reset stretch after request ends, in oscillator clocks
  localparam int RST_HOLD_CLKS  = 2048;
  // machine cycles per instruction class
  localparam logic [2:0] CYC_BIT_BRANCH = 3'h5;
  localparam logic [2:0] CYC_FOUR       = 3'h4;
  localparam logic [2:0] CYC_TWO        = 3'h2;
  // instruction classes
  typedef enum logic [2:0] {
    CRWC_IC_BIT_BRANCH,
    CRWC_IC_BRANCH_SUB,
    CRWC_IC_BIT_MANIP,
    CRWC_IC_LOAD,
    CRWC_IC_ALU,
    CRWC_IC_COND_BRANCH,
    CRWC_IC_PROG_CTRL
  } crwc_iclass_t;
  // core execution modes
  typedef enum logic [1:0] {
    CRWC_MODE_NORMAL,
    CRWC_MODE_IRQ,
    CRWC_MODE_NMI
  } crwc_mode_t;
endpackage : crwc_pkg

/* logic/crwc_clk_div.sv */
// clock divider: machine-cycle and timer-tick strobes
module crwc_clk_div
  import crwc_pkg::*;
#(
  parameter int MCYC = MCYC_PERIODS,
  parameter int TICK = TICK_PERIODS
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      mcyc_stb_o,
  output logic      tick_stb_o
);
  initial begin
    if (MCYC < 2 || MCYC > 255 || TICK < 2 || TICK > 255) begin
      $error("crwc_clk_div: divisor out of range");
    end
  end

  logic [7:0] mcnt_r;
  logic [7:0] tcnt_r;

  // counters cleared by reset so phases start aligned
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mcnt_r     <= 8'h00;
      mcyc_stb_o <= 1'b0;
    end else begin
      mcyc_stb_o <= (mcnt_r == 8'(MCYC - 1));
      mcnt_r     <= (mcnt_r == 8'(MCYC - 1)) ? 8'h00 : mcnt_r + 8'h01;
    end
  end

  // timer and watchdog tick
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tcnt_r     <= 8'h00;
      tick_stb_o <= 1'b0;
    end else begin
      tick_stb_o <= (tcnt_r == 8'(TICK - 1));
      tcnt_r     <= (tcnt_r == 8'(TICK - 1)) ? 8'h00 : tcnt_r + 8'h01;
    end
  end

  // clocks since the last strobe, saturating; checks the period
  // without unrolling a long repetition in the tools
  logic [7:0] mgap_r;
  logic [7:0] tgap_r;
  logic       mseen_r;
  logic       tseen_r;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mgap_r  <= 8'h00;
      mseen_r <= 1'b0;
    end else if (mcyc_stb_o) begin
      mgap_r  <= 8'h01;
      mseen_r <= 1'b1;
    end else if (mgap_r != 8'hff) begin
      mgap_r <= mgap_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgap_r  <= 8'h00;
      tseen_r <= 1'b0;
    end else if (tick_stb_o) begin
      tgap_r  <= 8'h01;
      tseen_r <= 1'b1;
    end else if (tgap_r != 8'hff) begin
      tgap_r <= tgap_r + 8'h01;
    end
  end

  property p_mcyc_period;
    @(posedge core_clk_i) disable iff (rst_i)
      mseen_r |-> (mcyc_stb_o == (mgap_r == 8'(MCYC)));
  endproperty
  a_mcyc_period: assert property (p_mcyc_period) else $error("machine cycle not 13 clocks");

  property p_tick_period;
    @(posedge core_clk_i) disable iff (rst_i)
      tseen_r |-> (tick_stb_o == (tgap_r == 8'(TICK)));
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick not 12 clocks");
endmodule : crwc_clk_div

/* sim/core_restart_wait_control_test.sv */
// self-checking testbench for the core restart / wait control block
module core_restart_wait_control_test import crwc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // short reset stretch keeps the run brief
  localparam int          HOLD = 8;
  localparam logic [11:0] VEC  = 12'h0a5c;
  logic         clk, rst, pin_n, wdg, gen, irq, nmi, wt, stp, return_from_interrupt, istart;
  crwc_iclass_t icls;
  logic [11:0]  vdat, vaddr, pc;
  logic [1:0]   mode;
  logic         core_rst, stk_clr, pcl, halted, irq_tk, nmi_tk, pclk, mcyc, tick, done;
  int           fails = 0;
  int           n_tests = 0;
  int           cyc = 0;

  // vector rom: other addresses read inverted so a wrong fetch shows
  assign vdat = (vaddr == RST_VEC_LO_ADDR || vaddr == RST_VEC_HI_ADDR) ? VEC : ~VEC;

  crwc_core_ctrl #(.RST_HOLD(HOLD)) dut (
    .core_clk_i(clk), .rst_i(rst), .rst_pin_n_i(pin_n), .wdg_rst_i(wdg),
    .global_irq_enable_i(gen), .irq_req_i(irq), .nmi_req_i(nmi), .wait_exec_i(wt),
    .stop_exec_i(stp), .return_from_interrupt_exec_i(return_from_interrupt), .instr_start_i(istart), .instr_class_i(icls),
    .vec_data_i(vdat), .core_reset_o(core_rst), .stack_clear_o(stk_clr), .vec_addr_o(vaddr),
    .pc_load_o(pcl), .pc_o(pc), .mode_o(mode), .halted_o(halted), .irq_take_o(irq_tk),
    .nmi_take_o(nmi_tk), .periph_clk_en_o(pclk), .mcyc_stb_o(mcyc), .tick_stb_o(tick),
    .instr_done_o(done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // inputs always move 1 ns after the rising edge
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  task ret();
    pulse(return_from_interrupt);
  endtask : ret

  // period between two strobes of one divider
  task automatic per(ref logic s, input int exp, input string nm);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 30) begin step(1); n++; end
    n = 0;
    do begin step(1); n++; end while (s !== 1'b1 && n < 30);
    chk(nm, 12'(n), 12'(exp));
  endtask : per

  // reset release, stretch count and vector fetch
  task automatic boot();
    int n;
    n = 0;
    while (core_rst === 1'b1 && n < 50) begin step(1); n++; end
    chk("hold", (n >= HOLD && n <= HOLD + 2), 1);
    n = 0;
    while (pcl !== 1'b1 && n < 4) begin step(1); n++; end
    chk("pc_load", pcl, 1);
    chk("pc", pc, VEC);
    chk("mode", mode, CRWC_MODE_NMI);
  endtask : boot

  task t_restart();
    int n;
    gen = 1'b1;
    irq = 1'b1;
    ret();
    chk("mode", mode, CRWC_MODE_NORMAL);
    n = 0;
    while (irq_tk !== 1'b1 && n < 3) begin step(1); n++; end
    chk("irq_take", irq_tk, 1);
    irq = 1'b0;
    ret();
    chk("mode", mode, CRWC_MODE_NORMAL);
  endtask : t_restart

  // wait or stop from the main routine, masked until enable rises
  task automatic t_wait_main(ref logic s);
    gen = 1'b0;
    pulse(s);
    chk("halted", halted, 1);
    chk("periph_clk", pclk, 1);
    per(mcyc, 13, "mcyc_wait");
    irq = 1'b1;
    nmi = 1'b1;
    step(6);
    chk("masked", halted, 1);
    nmi = 1'b0;
    gen = 1'b1;
    step(1);
    chk("wake", halted, 0);
    chk("irq_take", irq_tk, 1);
    irq = 1'b0;
    chk("mode", mode, CRWC_MODE_IRQ);
    ret();
    chk("mode", mode, CRWC_MODE_NORMAL);
  endtask : t_wait_main

  task t_skip();
    gen = 1'b1;
    irq = 1'b1;
    pulse(wt);
    irq = 1'b0;
    chk("skip", halted, 0);
    ret();
  endtask : t_skip

  task t_wait_nmi();
    gen = 1'b0;
    nmi = 1'b1;
    step(1);
    nmi = 1'b0;
    chk("nmi_take", nmi_tk, 1);
    gen = 1'b1;
    pulse(wt);
    chk("halted", halted, 1);
    irq = 1'b1;
    step(1);
    irq = 1'b0;
    chk("wake", halted, 0);
    chk("irq_take", irq_tk, 0);
    chk("mode", mode, CRWC_MODE_NMI);
    ret();
  endtask : t_wait_nmi

  task t_wait_irq();
    gen = 1'b1;
    irq = 1'b1;
    step(1);
    irq = 1'b0;
    pulse(wt);
    irq = 1'b1;
    step(1);
    irq = 1'b0;
    chk("wake", halted, 0);
    chk("irq_take", irq_tk, 0);
    chk("mode", mode, CRWC_MODE_IRQ);
    // request pending but not taken in irq mode: wait must be skipped
    irq = 1'b1;
    pulse(wt);
    irq = 1'b0;
    chk("skip_irq", halted, 0);
    step(1);
    pulse(wt);
    nmi = 1'b1;
    step(1);
    nmi = 1'b0;
    chk("nmi_take", nmi_tk, 1);
    ret();
    chk("mode", mode, CRWC_MODE_IRQ);
    step(1);
    ret();
    chk("mode", mode, CRWC_MODE_NORMAL);
  endtask : t_wait_irq

  // all sources off: only a pin or watchdog reset ends wait
  task automatic t_rst_wait(ref logic s, input logic v);
    gen = 1'b0;
    pulse(wt);
    step(20);
    chk("stuck", halted, 1);
    s = v;
    step(1);
    chk("core_reset", core_rst, 1);
    s = ~v;
    boot();
    chk("halted", halted, 0);
    ret();
  endtask : t_rst_wait

  task t_instr();
    int n;
    int e;
    for (int k = 0; k < 7; k++) begin
      icls = crwc_iclass_t'(k);
      e = (k == 0) ? 5 : ((k >= 5) ? 2 : 4);
      pulse(istart);
      n = 1;
      while (done !== 1'b1 && n < 100) begin step(1); n++; end
      chk("instr_len", (n > (e - 1) * 13 && n <= (e + 1) * 13), 1);
      step(2);
    end
  endtask : t_instr

  initial begin
    rst = 1'b1;
    {wdg, gen, irq, nmi, wt, stp, return_from_interrupt, istart} = '0;
    pin_n = 1'b1;
    icls = CRWC_IC_ALU;
    step(20);
    chk("core_reset", core_rst, 1);
    chk("stack_clear", stk_clr, 1);
    chk("periph_clk", pclk, 0);
    chk("mcyc_rst", mcyc, 0);
    chk("tick_rst", tick, 0);
    rst = 1'b0;
    boot();
    t_restart();
    per(mcyc, 13, "mcyc");
    per(tick, 12, "tick");
    t_wait_main(wt);
    t_wait_main(stp);
    t_skip();
    t_wait_nmi();
    t_wait_irq();
    t_instr();
    t_rst_wait(pin_n, 1'b0);
    t_rst_wait(wdg, 1'b1);
    report_and_stop();
  end
endmodule : core_restart_wait_control_test
